/* square_datapath_cfg.svh */
`ifndef SQUARE_DATAPATH_CFG_SVH
`define SQUARE_DATAPATH_CFG_SVH

// Register byte offsets
`define CTRL_OFFSET      8'h00
`define STATUS_OFFSET    8'h04
`define T3_OFFSET        8'h08
`define ACC_BASE         8'h20
`define ACC_REGION_MASK  8'he0
`define ACC_HI_BIT       2

// Mode register field positions
`define CTRL_FRAC_BIT    0
`define CTRL_MULTIPLY_SATURATION_BIT_BIT    1
`define CTRL_WIDE_BIT    2
`define CTRL_DATA_SATURATION_BIT_BIT    3
`define CTRL_SIGN_EXTENSION_MODE_BIT_BIT    4
`define CTRL_RDM_BIT     5
`define CTRL_LEGACY_BIT  6
`define CTRL_WIDTH       7
`define CTRL_RESET       7'h10

// Status register field positions
`define STATUS_CARRY_BIT 4

// Arithmetic constants
`define ROUND_ADD        42'h000_0000_8000
`define ROUND_TIE        16'h8000
`define MUL_SAT_VALUE    40'h00_7fff_ffff
`define MUL_SAT_INPUT    17'h1_8000

// Bus answers
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

/* square_datapath_pkg.sv */
package square_datapath_pkg;

  typedef enum logic [3:0] {
    op_idle              = 4'b0000,
    square_accumulate_op = 4'b0001,
    square_subtract_op   = 4'b0010,
    register_square_op   = 4'b0011,
    memory_square_op     = 4'b0100,
    square_distance_op   = 4'b0101,
    dual_mem_minus_acc   = 4'b0110,
    dual_acc_minus_mem   = 4'b0111,
    dual_mem_minus_tmp   = 4'b1000,
    dual_tmp_minus_mem   = 4'b1001
  } op_t;

endpackage : square_datapath_pkg

/* square_mult.sv */
`timescale 1ns/100ps
`include "square_datapath_cfg.svh"

module square_mult (
  // Multiplier operands, 17-bit signed
  input  wire logic [16:0] mul_a,
  input  wire logic [16:0] mul_b,
  // Mode bits
  input  wire logic        frac_mode,
  input  wire logic        mul_sat_mode,
  // Product sign-extended to accumulator width
  output logic      [39:0] product
);

  logic signed [33:0] raw;
  logic        [34:0] scaled;
  logic               sat_case;

  assign raw = $signed(mul_a) * $signed(mul_b);
  assign scaled = frac_mode ? {raw, 1'b0} : {raw[33], raw};
  // Only the fractional square of the most negative word can overflow
  assign sat_case = frac_mode && mul_sat_mode &&
                    (mul_a == `MUL_SAT_INPUT) && (mul_b == `MUL_SAT_INPUT);

  assign product = sat_case ? `MUL_SAT_VALUE
                            : {{5{scaled[34]}}, scaled};

endmodule : square_mult

/* sat_clip.sv */
`timescale 1ns/100ps

module sat_clip #(
  parameter int IN_W     = 42,
  parameter int OUT_W    = 40,
  parameter int NARROW_W = 32
) (
  // Exact signed result
  input  wire logic [IN_W-1:0]  exact,
  // Check against the narrow range instead of the full width
  input  wire logic             narrow,
  input  wire logic             sat_en,
  // Clipped result and overflow
  output logic      [OUT_W-1:0] result,
  output logic                  ovf
);

  localparam logic [OUT_W-1:0] MAX_N =
    {{(OUT_W-NARROW_W+1){1'b0}}, {(NARROW_W-1){1'b1}}};
  localparam logic [OUT_W-1:0] MAX_O = {1'b0, {(OUT_W-1){1'b1}}};

  if (NARROW_W > OUT_W || OUT_W >= IN_W) begin : g_bad
    $error("sat_clip width parameters out of range");
  end

  logic fits_out;
  logic fits_nar;
  logic pos;
  logic [OUT_W-1:0] limit;

  assign fits_out = (&exact[IN_W-1:OUT_W-1]) | ~(|exact[IN_W-1:OUT_W-1]);
  assign fits_nar = (&exact[IN_W-1:NARROW_W-1]) |
                    ~(|exact[IN_W-1:NARROW_W-1]);
  assign ovf = narrow ? ~fits_nar : ~fits_out;
  assign pos = ~exact[IN_W-1];
  assign limit = narrow ? (pos ? MAX_N : ~MAX_N) : (pos ? MAX_O : ~MAX_O);
  assign result = (ovf && sat_en) ? limit : exact[OUT_W-1:0];

endmodule : sat_clip

/* square_mac_dual_sub_datapath.sv */
`timescale 1ns/100ps
`include "square_datapath_cfg.svh"

module square_mac_dual_sub_datapath #(
  parameter int ADDR_W = 8,
  parameter int MEM_AW = 16
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Instruction from decode
  input  wire logic                      op_valid,
  input  wire square_datapath_pkg::op_t  op_code,
  input  wire logic [1:0]                src_sel,
  input  wire logic [1:0]                dst_sel,
  input  wire logic                      round_en,
  input  wire logic                      sq_from_mem,
  input  wire logic                      t3_load,
  // Operands from fetch
  input  wire logic [15:0]               mem_x,
  input  wire logic [15:0]               mem_y,
  input  wire logic [15:0]               temp_reg,
  input  wire logic [MEM_AW-1:0]         dbl_addr,
  output logic [MEM_AW-1:0]              dbl_pair_addr,
  input  wire logic [15:0]               dbl_msw,
  input  wire logic [15:0]               dbl_lsw,
  // Results and status
  output logic                           op_done,
  output logic [3:0]                     acov_flags,
  output logic                           carry_flag,
  output logic [15:0]                    t3_out
);

  if (ADDR_W < 8 || MEM_AW < 1) begin : g_bad
    $error("datapath parameters out of range");
  end

  // State
  logic [39:0]              acc_reg [0:3];
  logic [`CTRL_WIDTH-1:0]   ctrl_reg;
  logic [3:0]               acov_reg;
  logic                     carry_reg;
  logic [15:0]              t3_reg;
  logic                     done_reg;

  // Mode bits
  logic frac_mode;
  logic multiply_saturation_bit_mode;
  logic wide_mode;
  logic data_saturation_bit_mode;
  logic sign_extension_mode_bit_mode;
  logic rdm_mode;

  assign frac_mode   = ctrl_reg[`CTRL_FRAC_BIT];
  assign multiply_saturation_bit_mode   = ctrl_reg[`CTRL_MULTIPLY_SATURATION_BIT_BIT];
  assign wide_mode   = ctrl_reg[`CTRL_WIDE_BIT];
  assign data_saturation_bit_mode   = ctrl_reg[`CTRL_DATA_SATURATION_BIT_BIT];
  assign sign_extension_mode_bit_mode   = ctrl_reg[`CTRL_SIGN_EXTENSION_MODE_BIT_BIT];
  assign rdm_mode    = ctrl_reg[`CTRL_RDM_BIT];

  // Opcode decode
  logic op_fire;
  logic is_sqa;
  logic is_sqs;
  logic is_sqr;
  logic is_memory_square_op;
  logic is_dist;
  logic is_dual;
  logic is_mac;

  assign op_fire = op_valid && (op_code != square_datapath_pkg::op_idle);
  assign is_sqa  = op_code == square_datapath_pkg::square_accumulate_op;
  assign is_sqs  = op_code == square_datapath_pkg::square_subtract_op;
  assign is_sqr  = op_code == square_datapath_pkg::register_square_op;
  assign is_memory_square_op = op_code == square_datapath_pkg::memory_square_op;
  assign is_dist = op_code == square_datapath_pkg::square_distance_op;
  assign is_dual = (op_code == square_datapath_pkg::dual_mem_minus_acc) ||
                   (op_code == square_datapath_pkg::dual_acc_minus_mem) ||
                   (op_code == square_datapath_pkg::dual_mem_minus_tmp) ||
                   (op_code == square_datapath_pkg::dual_tmp_minus_mem);
  assign is_mac  = is_sqa || is_sqs || is_sqr || is_memory_square_op || is_dist;

  // Accumulator reads happen before this cycle's write-back
  logic [39:0] acc_src;
  logic [39:0] acc_dst;

  assign acc_src = acc_reg[src_sel];
  assign acc_dst = acc_reg[dst_sel];

  // Multiplier input
  logic        use_mem_sq;
  logic [16:0] mul_in;
  logic [39:0] product;

  assign use_mem_sq = is_memory_square_op || (sq_from_mem && (is_sqa || is_sqs));
  assign mul_in = use_mem_sq ? {mem_x[15], mem_x}
                             : acc_src[32:16];

  square_mult u_mult (
    .mul_a        (mul_in),
    .mul_b        (mul_in),
    .frac_mode    (frac_mode),
    .mul_sat_mode (multiply_saturation_bit_mode),
    .product      (product)
  );

  // MAC adder: register squares start from zero
  logic [41:0] mac_base;
  logic [41:0] mac_prod;
  logic [41:0] mac_sum;
  logic [41:0] rnd_add;
  logic        rnd_tie;
  logic        round_on;
  logic [41:0] mac_exact;
  logic [39:0] mac_res;
  logic        mac_ovf;

  assign mac_base = (is_sqa || is_sqs || is_dist)
                    ? {{2{acc_dst[39]}}, acc_dst} : 42'h000_0000_0000;
  assign mac_prod = {{2{product[39]}}, product};
  assign mac_sum  = is_sqs ? mac_base - mac_prod
                           : mac_base + mac_prod;

  // Rounding mode 1 breaks an exact half towards even
  assign round_on = round_en && !is_dist;
  assign rnd_add  = mac_sum + `ROUND_ADD;
  assign rnd_tie  = rdm_mode && (mac_sum[15:0] == `ROUND_TIE);
  assign mac_exact = round_on
                     ? {rnd_add[41:17], rnd_add[16] & ~rnd_tie, 16'h0000}
                     : mac_sum;

  sat_clip #(
    .IN_W     (42),
    .OUT_W    (40),
    .NARROW_W (32)
  ) u_mac_clip (
    .exact  (mac_exact),
    .narrow (!wide_mode),
    .sat_en (data_saturation_bit_mode),
    .result (mac_res),
    .ovf    (mac_ovf)
  );

  // Distance subtraction on the 40-bit ALU
  logic [39:0] dist_x;
  logic [39:0] dist_y;
  logic [41:0] dist_exact;
  logic [39:0] dist_res;
  logic        dist_ovf;
  logic        dist_carry;
  logic        dist_wide;

  // A 16-bit word moved up 16 places cannot leave 40 bits, so the
  // shift stage itself never reports overflow, legacy mode or not
  assign dist_x = {{8{sign_extension_mode_bit_mode & mem_x[15]}}, mem_x, 16'h0000};
  assign dist_y = {{8{sign_extension_mode_bit_mode & mem_y[15]}}, mem_y, 16'h0000};
  assign dist_exact = {{2{dist_x[39]}}, dist_x} -
                      {{2{dist_y[39]}}, dist_y};
  assign dist_wide  = wide_mode;
  // Carry set means no borrow
  assign dist_carry = dist_wide ? (dist_x >= dist_y)
                                : (dist_x[31:0] >= dist_y[31:0]);

  sat_clip #(
    .IN_W     (42),
    .OUT_W    (40),
    .NARROW_W (32)
  ) u_dist_clip (
    .exact  (dist_exact),
    .narrow (!dist_wide),
    .sat_en (data_saturation_bit_mode),
    .result (dist_res),
    .ovf    (dist_ovf)
  );

  // Dual 16-bit subtraction operands
  logic [23:0] mem_hi;
  logic [23:0] tmp_hi;
  logic        mem_first;
  logic        use_tmp;
  logic [23:0] other_hi;
  logic [15:0] other_lo;
  logic [23:0] a_hi;
  logic [23:0] b_hi;
  logic [15:0] a_lo;
  logic [15:0] b_lo;

  assign dbl_pair_addr = {dbl_addr[MEM_AW-1:1], ~dbl_addr[0]};
  assign mem_hi = {{8{sign_extension_mode_bit_mode & dbl_msw[15]}}, dbl_msw};
  assign tmp_hi = {{8{sign_extension_mode_bit_mode & temp_reg[15]}}, temp_reg};
  assign use_tmp = (op_code == square_datapath_pkg::dual_mem_minus_tmp) ||
                   (op_code == square_datapath_pkg::dual_tmp_minus_mem);
  assign mem_first =
    (op_code == square_datapath_pkg::dual_mem_minus_acc) ||
    (op_code == square_datapath_pkg::dual_mem_minus_tmp);
  assign other_hi = use_tmp ? tmp_hi : acc_src[39:16];
  assign other_lo = use_tmp ? temp_reg : acc_src[15:0];
  assign a_hi = mem_first ? mem_hi : other_hi;
  assign b_hi = mem_first ? other_hi : mem_hi;
  assign a_lo = mem_first ? dbl_lsw : other_lo;
  assign b_lo = mem_first ? other_lo : dbl_lsw;

  // Both halves computed in the same cycle
  logic [17:0] lo_exact;
  logic [25:0] hi_exact;
  logic [15:0] lo_res;
  logic [23:0] hi_res;
  logic        lo_ovf;
  logic        hi_ovf;
  logic        dual_ovf;
  logic        dual_carry;

  assign lo_exact = {{2{a_lo[15]}}, a_lo} - {{2{b_lo[15]}}, b_lo};
  assign hi_exact = {{2{a_hi[23]}}, a_hi} - {{2{b_hi[23]}}, b_hi};
  assign dual_carry = a_hi[15:0] >= b_hi[15:0];

  sat_clip #(
    .IN_W     (18),
    .OUT_W    (16),
    .NARROW_W (16)
  ) u_lo_clip (
    .exact  (lo_exact),
    .narrow (1'b1),
    .sat_en (data_saturation_bit_mode),
    .result (lo_res),
    .ovf    (lo_ovf)
  );

  sat_clip #(
    .IN_W     (26),
    .OUT_W    (24),
    .NARROW_W (16)
  ) u_hi_clip (
    .exact  (hi_exact),
    .narrow (1'b1),
    .sat_en (data_saturation_bit_mode),
    .result (hi_res),
    .ovf    (hi_ovf)
  );

  assign dual_ovf = lo_ovf | hi_ovf;

  // Write-back ports; on a clash the square result wins
  logic        wa_en;
  logic [39:0] wa_data;
  logic        wa_ovf;
  logic        wb_en;
  logic [3:0]  acov_set;

  assign wa_en   = op_fire && (is_mac || is_dual);
  assign wa_data = is_dual ? {hi_res, lo_res} : mac_res;
  assign wa_ovf  = is_dual ? dual_ovf : mac_ovf;
  assign wb_en   = op_fire && is_dist && (src_sel != dst_sel);

  for (genvar i = 0; i < 4; i++) begin : g_acov
    assign acov_set[i] =
      (wa_en && (dst_sel == 2'(i)) && wa_ovf) ||
      (op_fire && is_dist && (src_sel == 2'(i)) && dist_ovf);
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (reset) begin
        acc_reg[i] <= 40'h00_0000_0000;
      end else if (wa_en && dst_sel == 2'(i)) begin
        acc_reg[i] <= wa_data;
      end else if (wb_en && src_sel == 2'(i)) begin
        acc_reg[i] <= dist_res;
      end
    end
  end

  logic carry_next;

  assign carry_next = !op_fire ? carry_reg
                    : is_dist  ? dist_carry
                    : is_dual  ? dual_carry
                    : carry_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      carry_reg <= 1'b0;
      t3_reg    <= 16'h0000;
      done_reg  <= 1'b0;
    end else begin
      carry_reg <= carry_next;
      done_reg  <= op_fire;
      if (op_fire && use_mem_sq && t3_load) begin
        t3_reg <= mem_x;
      end
    end
  end

  // AXI4-Lite write path: address and data are held until both arrive
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              wr_go;
  logic              wr_ctrl;
  logic              wr_status;
  logic [3:0]        acov_clr;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign wr_go     = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_ctrl   = wr_go && (awaddr_reg == ADDR_W'(`CTRL_OFFSET));
  assign wr_status = wr_go && (awaddr_reg == ADDR_W'(`STATUS_OFFSET));
  assign acov_clr  = (wr_status && wstrb_reg[0]) ? wdata_reg[3:0] : 4'h0;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wr_ctrl || wr_status) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Mode register and sticky flags; a new overflow beats a clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_reg <= `CTRL_RESET;
      acov_reg <= 4'h0;
    end else begin
      if (wr_ctrl && wstrb_reg[0]) begin
        ctrl_reg <= wdata_reg[`CTRL_WIDTH-1:0];
      end
      acov_reg <= (acov_reg & ~acov_clr) | acov_set;
    end
  end

  // AXI4-Lite read path
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        rd_ctrl;
  logic        rd_status;
  logic        rd_t3;
  logic        rd_acc;
  logic [39:0] rd_acc_val;
  logic [31:0] rd_word;

  assign s_axi_arready = !rvalid_reg;
  assign rd_ctrl   = s_axi_araddr == ADDR_W'(`CTRL_OFFSET);
  assign rd_status = s_axi_araddr == ADDR_W'(`STATUS_OFFSET);
  assign rd_t3     = s_axi_araddr == ADDR_W'(`T3_OFFSET);
  assign rd_acc    = ((s_axi_araddr & ADDR_W'(`ACC_REGION_MASK)) ==
                      ADDR_W'(`ACC_BASE)) && (s_axi_araddr[1:0] == 2'h0);
  assign rd_acc_val = acc_reg[s_axi_araddr[4:3]];
  assign rd_word =
    rd_ctrl   ? {{(32-`CTRL_WIDTH){1'b0}}, ctrl_reg} :
    rd_status ? {27'h000_0000, carry_reg, acov_reg} :
    rd_t3     ? {16'h0000, t3_reg} :
    !rd_acc   ? 32'h0000_0000 :
    s_axi_araddr[`ACC_HI_BIT] ? {24'h00_0000, rd_acc_val[39:32]}
                              : rd_acc_val[31:0];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= (rd_ctrl || rd_status || rd_t3 || rd_acc)
                    ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;
  assign op_done      = done_reg;
  assign acov_flags   = acov_reg;
  assign carry_flag   = carry_reg;
  assign t3_out       = t3_reg;

endmodule : square_mac_dual_sub_datapath

/* square_datapath_properties.sv */
`timescale 1ns/100ps

module square_datapath_checker #(
  parameter int ADDR_W = 8,
  parameter int MEM_AW = 16
) (
  // Clock and reset
  input wire logic                     core_clk,
  input wire logic                     reset,
  // Bus handshakes
  input wire logic [1:0]               s_axi_bresp,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic                     s_axi_rvalid,
  // Instruction and operands
  input wire logic                     op_valid,
  input wire square_datapath_pkg::op_t op_code,
  input wire logic [1:0]               dst_sel,
  input wire logic                     t3_load,
  input wire logic [15:0]              mem_x,
  input wire logic [15:0]              temp_reg,
  input wire logic [MEM_AW-1:0]        dbl_addr,
  input wire logic [MEM_AW-1:0]        dbl_pair_addr,
  input wire logic [15:0]              dbl_msw,
  input wire logic [15:0]              dbl_lsw,
  // Results
  input wire logic                     op_done,
  input wire logic [3:0]               acov_flags,
  input wire logic                     carry_flag,
  input wire logic [15:0]              t3_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  wire        op_taken = op_valid && op_code != square_datapath_pkg::op_idle;
  wire [16:0] lo_diff  = {temp_reg[15], temp_reg} - {dbl_lsw[15], dbl_lsw};
  wire        lo_ovf   = lo_diff[16] ^ lo_diff[15];
  wire        hi_ge    = temp_reg >= dbl_msw;

  sequence op_take;
    op_taken;
  endsequence
  sequence tmp_mem_take;
    op_valid && op_code == square_datapath_pkg::dual_tmp_minus_mem;
  endsequence
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  chk_done_pulse: assert property (op_take |=> op_done)
    else $error("op_done missing after op");
  chk_done_cause: assert property (op_done |-> $past(op_taken))
    else $error("op_done without op");
  chk_pair_addr: assert property (
    dbl_pair_addr == (dbl_addr ^ MEM_AW'(1)))
    else $error("pair address wrong");
  chk_t3_load: assert property (
    op_valid && op_code == square_datapath_pkg::memory_square_op && t3_load
    |=> t3_out == $past(mem_x))
    else $error("t3 not loaded");
  chk_t3_hold: assert property (!(op_valid && t3_load) |=> $stable(t3_out))
    else $error("t3 changed without load");
  chk_carry_hold: assert property (
    !(op_valid && op_code >= square_datapath_pkg::square_distance_op)
    |=> $stable(carry_flag))
    else $error("carry changed");
  chk_dual_ovf: assert property (
    tmp_mem_take ##0 lo_ovf |=> acov_flags[$past(dst_sel)])
    else $error("dual low overflow not flagged");
  chk_dual_carry: assert property (
    tmp_mem_take |=> carry_flag == $past(hi_ge))
    else $error("dual carry wrong");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : square_datapath_checker

bind square_mac_dual_sub_datapath square_datapath_checker #(
  .ADDR_W(ADDR_W),
  .MEM_AW(MEM_AW)
) chk_inst (.*);

/* operand_fetch_model.sv */
`timescale 1ns/100ps

module operand_fetch_model (
  // Double-word request
  input  wire logic [15:0] dbl_addr,
  input  wire logic [15:0] dbl_pair_addr,
  // Words returned
  output logic      [15:0] dbl_msw,
  output logic      [15:0] dbl_lsw
);
  // Odd words hold full-scale negative to reach overflow paths
  function automatic logic [15:0] word_at(input logic [15:0] a);
    return a[0] ? 16'h8000 : {a[7:0], 8'h34};
  endfunction : word_at
  assign dbl_msw = word_at(dbl_addr);
  assign dbl_lsw = word_at(dbl_pair_addr);
endmodule : operand_fetch_model

/* square_mac_dual_sub_datapath_tb.sv */
`timescale 1ns/100ps
`include "square_datapath_cfg.svh"

module square_mac_dual_sub_datapath_tb;
  logic        core_clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, op_valid;
  logic        round_en, sq_from_mem, t3_load, op_done, carry_flag;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, acov_flags;
  logic [1:0]  s_axi_bresp, s_axi_rresp, src_sel, dst_sel;
  logic [15:0] mem_x, mem_y, temp_reg, dbl_addr, dbl_pair_addr;
  logic [15:0] dbl_msw, dbl_lsw, t3_out;
  square_datapath_pkg::op_t op_code;
  int          error_cnt, tests_run;

  square_mac_dual_sub_datapath square_mac_dual_sub_datapath_inst (.*);
  operand_fetch_model operand_fetch_model_inst (.*);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task summarize;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task hang;
    error_cnt++;
    $display("[FAIL] %0t bus wait ran out", $time);
    summarize();
  endtask : hang

  // Ready is stable between edges, so sample it at the falling edge
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      r  = s_axi_bresp;
      if (s_axi_bvalid) begin
        @(posedge core_clk);
        s_axi_bready <= 1'b0;
        return;
      end
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    hang();
  endtask : axw

  task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta;
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready;
      d  = s_axi_rdata;
      r  = s_axi_rresp;
      if (s_axi_rvalid) begin
        @(posedge core_clk);
        s_axi_rready <= 1'b0;
        return;
      end
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    hang();
  endtask : axr

  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    cmp(d, e);
  endtask : rd

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    cmp({30'h0, r}, {30'h0, `RESP_OKAY});
  endtask : wr

  task acc(input int i, input logic [39:0] e);
    rd(8'(8'h20 + 8 * i), e[31:0]);
    rd(8'(8'h24 + 8 * i), {24'h0, e[39:32]});
  endtask : acc

  task op(input square_datapath_pkg::op_t c, input logic [1:0] s,
          input logic [1:0] d, input logic [15:0] x, input logic [15:0] y,
          input logic [2:0] f);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code  <= c;
    src_sel  <= s;
    dst_sel  <= d;
    mem_x    <= x;
    mem_y    <= y;
    {sq_from_mem, round_en, t3_load} <= f;
    @(posedge core_clk);
    op_valid <= 1'b0;
    @(negedge core_clk);
    cmp({31'h0, op_done}, 32'h1);
  endtask : op

  task t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'h00, 32'h10);
    axr(8'h10, d, r);
    cmp({30'h0, r}, {30'h0, `RESP_SLVERR});
    cmp(d, 32'h0);
    axw(8'h08, 32'h1234, r);
    cmp({30'h0, r}, {30'h0, `RESP_SLVERR});
    wr(8'h00, 32'h18);
  endtask : t_regs

  // Accumulator 3 and the temporary stay zero, so the two orders differ
  task t_dual;
    for (int i = 0; i < 4; i++) begin
      op(square_datapath_pkg::op_t'(4'(6 + i)), 2'd3, 2'd0, 0, 0, 0);
      acc(0, i[0] ? 40'hff_fdcc_7fff : 40'h00_0234_8000);
      rd(8'h04, i[0] ? 32'h01 : 32'h10);
      wr(8'h04, 32'h0f);
    end
  endtask : t_dual

  task t_square;
    op(square_datapath_pkg::memory_square_op, 0, 0, 16'h8000, 0, 3'b001);
    acc(0, 40'h00_4000_0000);
    cmp({16'h0, t3_out}, 32'h8000);
    op(square_datapath_pkg::register_square_op, 0, 2, 0, 0, 0);
    acc(2, 40'h00_1000_0000);
    op(square_datapath_pkg::square_subtract_op, 0, 2, 16'h2, 0, 3'b100);
    acc(2, 40'h00_0fff_fffc);
  endtask : t_square

  task t_overflow;
    op(square_datapath_pkg::memory_square_op, 0, 3, 16'h8000, 0, 0);
    op(square_datapath_pkg::square_accumulate_op, 0, 3, 16'h8000, 0, 3'b100);
    acc(3, 40'h00_7fff_ffff);
    rd(8'h04, 32'h08);
    wr(8'h00, 32'h14);
    op(square_datapath_pkg::memory_square_op, 0, 3, 16'h8000, 0, 0);
    op(square_datapath_pkg::square_accumulate_op, 0, 3, 16'h8000, 0, 3'b100);
    acc(3, 40'h00_8000_0000);
    wr(8'h00, 32'h18);
    op(square_datapath_pkg::memory_square_op, 0, 1, 16'h00ff, 0, 3'b010);
    acc(1, 40'h00_0001_0000);
  endtask : t_overflow

  task t_frac;
    wr(8'h00, 32'h3b);
    op(square_datapath_pkg::memory_square_op, 0, 1, 16'h8000, 0, 0);
    acc(1, 40'h00_7fff_ffff);
    op(square_datapath_pkg::memory_square_op, 0, 1, 16'h0003, 0, 0);
    acc(1, 40'h00_0000_0012);
    op(square_datapath_pkg::memory_square_op, 0, 1, 16'h0080, 0, 3'b010);
    acc(1, 40'h00_0000_0000);
    wr(8'h00, 32'h18);
  endtask : t_frac

  task t_distance;
    op(square_datapath_pkg::square_distance_op, 2, 0, 16'hffff, 16'h1, 0);
    acc(0, 40'h00_40ff_e001);
    acc(2, 40'hff_fffe_0000);
    rd(8'h04, 32'h18);
  endtask : t_distance

  initial begin
    error_cnt = 0;
    tests_run = 0;
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, op_valid, round_en, sq_from_mem, t3_load} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, src_sel, dst_sel} = '0;
    {mem_x, mem_y, temp_reg} = '0;
    s_axi_wstrb = 4'hf;
    dbl_addr = 16'h0002;
    op_code = square_datapath_pkg::op_idle;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    t_dual();
    t_square();
    t_overflow();
    t_frac();
    t_distance();
    summarize();
  end
endmodule : square_mac_dual_sub_datapath_tb
